// ---- hw/mbrm_pkg.sv ----
// constants, types and message length decode for the memory bus requester
// Overview of operation
// - bus messages are requests, replies or notifications
// - entries serviced and answered in arrival order
// - message cycles driven in order 0..C-1
// - control code driven beside 16-bit byte pair
// - idle code 111 means data lines released
// - memory length field selects 1 to 16 bytes
// - byte-count flag clear moves one register byte
// - byte-count flag set moves two register bytes
// - two-byte register access uses even address
// - cycle 0 upper byte holds type nibble
// - address byte 2, then bytes 1 and 0
// - reads last two cycles, codes 000, 001
// - writes add data pairs, next-to-last code 000
// - register write spans three cycles: 001,000,001
package mbrm_pkg;
   typedef logic [2:0] mbrm_ccc_t;
   typedef logic [3:0] mbrm_nib_t;
   typedef enum logic {ST_IDLE, ST_SEND} mbrm_state_e;

   // ***************************************
   // bus control codes
   // ***************************************
   localparam mbrm_ccc_t CC_IDLE     = 3'h7;
   localparam mbrm_ccc_t CC_REQ      = 3'h1;
   localparam mbrm_ccc_t CC_REQ_NTL  = 3'h0;
   localparam mbrm_ccc_t CC_RPL_WARN = 3'h2;
   localparam mbrm_ccc_t CC_RPL_ACK  = 3'h6;
   localparam mbrm_ccc_t CC_NOTIFY   = 3'h4;

   // ***************************************
   // request type nibbles and layout
   // ***************************************
   localparam mbrm_nib_t RT_MEM_RD     = 4'h0;
   localparam mbrm_nib_t RT_MEM_RMW_RD = 4'h1;
   localparam mbrm_nib_t RT_MEM_WR     = 4'h2;
   localparam mbrm_nib_t RT_MEM_RMW_WR = 4'h3;
   localparam mbrm_nib_t RT_IC_RD      = 4'h4;
   localparam mbrm_nib_t RT_IC_WR      = 4'h5;
   localparam int        PIPE_DEPTH    = 3;
   localparam logic [3:0] ADDR_CYCLES  = 4'h2;
   localparam logic [3:0] IC_WR_CYCLES = 4'h3;

   // total cycles C of a request, from its cycle 0 upper byte
   function automatic logic [3:0] msg_cycles(input mbrm_nib_t typ, input mbrm_nib_t low);
      logic [3:0] c;
      c = ADDR_CYCLES;
      if (typ == RT_MEM_WR || typ == RT_MEM_RMW_WR) begin
         c = ADDR_CYCLES + {1'b0, low[3:1]} + 4'h1; // pairs of len+1 bytes
      end else if (typ == RT_IC_WR) begin
         c = IC_WR_CYCLES;
      end
      return c;
   endfunction
endpackage

// ---- hw/mbrm_pipe.sv ----
// outstanding-request pipeline tracker watching the shared memory bus
`timescale 1ns/1ps
module mbrm_pipe #(
   parameter int DEPTH = 3
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire mbrm_pkg::mbrm_ccc_t ctl_in,
   input  wire logic [15:0]         md_in,
   input  wire logic                own_drive,
   output logic [1:0]               count,
   output logic                     full,
   output logic                     msg_busy,
   output logic                     retire_own,
   output mbrm_pkg::mbrm_nib_t      head_type
);
   import mbrm_pkg::*;

   logic [3:0] left_r;
   mbrm_nib_t  type_r [DEPTH];
   logic       own_r  [DEPTH];
   logic [1:0] wr_idx_r;
   logic [1:0] rd_idx_r;
   logic [1:0] count_r;
   logic       start;
   logic       add;
   logic       retire;

   function automatic logic [1:0] next_idx(input logic [1:0] i);
      return (i == 2'(DEPTH - 1)) ? 2'h0 : i + 2'h1;
   endfunction

   // ***************************************
   // message classification
   // ***************************************
   assign start  = (left_r == 4'h0) && (ctl_in == CC_REQ || ctl_in == CC_REQ_NTL);
   assign add    = start && (count_r != 2'(DEPTH));
   assign retire = (ctl_in == CC_RPL_WARN || ctl_in == CC_RPL_ACK) && (count_r != 2'h0);
   assign count      = count_r;
   assign full       = (count_r == 2'(DEPTH));
   assign msg_busy   = (left_r != 4'h0);
   assign head_type  = type_r[rd_idx_r];
   assign retire_own = retire && own_r[rd_idx_r];

   // cycles left in the request now on the bus
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         left_r <= 4'h0;
      end else if (start) begin
         left_r <= msg_cycles(md_in[15:12], md_in[11:8]) - 4'h1;
      end else if (left_r != 4'h0) begin
         left_r <= left_r - 4'h1;
      end
   end

   // arrival-order entry storage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_idx_r <= 2'h0;
         rd_idx_r <= 2'h0;
         count_r  <= 2'h0;
         for (int i = 0; i < DEPTH; i++) begin
            type_r[i] <= 4'h0;
            own_r[i]  <= 1'b0;
         end
      end else begin
         if (add) begin
            type_r[wr_idx_r] <= md_in[15:12];
            own_r[wr_idx_r]  <= own_drive;
            wr_idx_r         <= next_idx(wr_idx_r);
         end
         if (retire) begin
            rd_idx_r <= next_idx(rd_idx_r);
         end
         count_r <= count_r + 2'(add) - 2'(retire);
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   property p_depth;
      @(posedge clk) disable iff (reset) count_r <= 2'(DEPTH);
   endproperty
   a_depth: assert property (p_depth) else $error("pipeline over depth");

   property p_add;
      @(posedge clk) disable iff (reset)
         (add && !retire) |=> count_r == $past(count_r) + 2'h1;
   endproperty
   a_add: assert property (p_add) else $error("request did not add entry");

   property p_notify;
      @(posedge clk) disable iff (reset) (ctl_in == CC_NOTIFY) |=> $stable(count_r);
   endproperty
   a_notify: assert property (p_notify) else $error("notification moved pipeline");

   property p_order;
      @(posedge clk) disable iff (reset)
         retire |=> rd_idx_r == next_idx($past(rd_idx_r)) && count_r <= $past(count_r);
   endproperty
   a_order: assert property (p_order) else $error("retire out of order");

   c_full: cover property (@(posedge clk) disable iff (reset) count_r == 2'(DEPTH));
endmodule

// ---- hw/mbrm_requester.sv ----
// memory bus requester: frames request messages onto the shared bus
`timescale 1ns/1ps
module mbrm_requester (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  wire mbrm_pkg::mbrm_nib_t req_type,
   input  wire mbrm_pkg::mbrm_nib_t req_len,
   input  wire logic                req_two_byte,
   input  wire logic [23:0]         req_addr,
   input  wire logic [15:0]         wr_data,
   output logic                     wr_data_take,
   input  wire logic                bus_grant,
   input  wire mbrm_pkg::mbrm_ccc_t ctl_in,
   output mbrm_pkg::mbrm_ccc_t      ctl_out,
   output logic                     ctl_oe,
   input  wire logic [15:0]         md_in,
   output logic [15:0]              md_out,
   output logic                     md_oe,
   output logic [1:0]               pipe_count,
   output logic                     own_retire,
   output logic                     busy
);
   import mbrm_pkg::*;

   mbrm_state_e state_r;
   logic [23:0] addr_r;
   logic [3:0]  t_r;
   logic [3:0]  last_r;
   mbrm_ccc_t   ctl_out_r;
   logic [15:0] md_out_r;
   logic        oe_r;
   logic        full;
   logic        msg_busy;
   logic        accept;
   logic        is_ic;
   mbrm_nib_t   low_nib;
   logic [23:0] addr_fix;
   logic [3:0]  req_last;

   // control code for message cycle t of a message ending at last
   function automatic mbrm_ccc_t code_for(input logic [3:0] t, input logic [3:0] last);
      return (t == last - 4'h1) ? CC_REQ_NTL : CC_REQ;
   endfunction

   // ***************************************
   // pipeline tracker
   // ***************************************
   mbrm_pipe #(
      .DEPTH(PIPE_DEPTH)
   ) u_pipe (
      .clk       (clk),
      .reset     (reset),
      .ctl_in    (ctl_in),
      .md_in     (md_in),
      .own_drive (ctl_oe),
      .count     (pipe_count),
      .full      (full),
      .msg_busy  (msg_busy),
      .retire_own(own_retire),
      .head_type ()
   );

   // ***************************************
   // request intake
   // ***************************************
   assign is_ic    = (req_type == RT_IC_RD || req_type == RT_IC_WR);
   assign low_nib  = is_ic ? {3'h0, req_two_byte} : req_len;
   assign addr_fix = {req_addr[23:1],
                      req_addr[0] & ~(is_ic & req_two_byte)};
   assign req_last = msg_cycles(req_type, low_nib) - 4'h1;
   // start only on an idle, granted bus with room in the pipeline
   assign req_ready = (state_r == ST_IDLE) && bus_grant && (ctl_in == CC_IDLE)
                      && !msg_busy && !full;
   assign accept    = req_valid && req_ready;
   assign wr_data_take = (state_r == ST_SEND) && (t_r != 4'h0) && (t_r != last_r);
   assign busy      = (state_r == ST_SEND);
   assign ctl_out   = ctl_out_r;
   assign md_out    = md_out_r;
   assign ctl_oe    = oe_r;
   assign md_oe     = oe_r;

   // sequencer state and cycle counter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         t_r     <= 4'h0;
         last_r  <= 4'h0;
         addr_r  <= 24'h000000;
      end else if (state_r == ST_IDLE) begin
         if (accept) begin
            state_r <= ST_SEND;
            t_r     <= 4'h0;
            last_r  <= req_last;
            addr_r  <= addr_fix;
         end
      end else if (t_r == last_r) begin
         state_r <= ST_IDLE;
      end else begin
         t_r <= t_r + 4'h1;
      end
   end

   // bus drivers, one message cycle per clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_out_r <= CC_IDLE;
         md_out_r  <= 16'h0000;
         oe_r      <= 1'b0;
      end else if (state_r == ST_IDLE) begin
         if (accept) begin
            ctl_out_r <= code_for(4'h0, req_last);
            md_out_r  <= {req_type, low_nib, addr_fix[23:16]};
            oe_r      <= 1'b1;
         end
      end else if (t_r == last_r) begin
         ctl_out_r <= CC_IDLE;
         oe_r      <= 1'b0;
      end else begin
         ctl_out_r <= code_for(t_r + 4'h1, last_r);
         md_out_r  <= (t_r == 4'h0) ? addr_r[15:0] : wr_data;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   property p_idle_hiz;
      @(posedge clk) disable iff (reset) ctl_out == CC_IDLE |-> !md_oe;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("data driven while idle");

   property p_full_block;
      @(posedge clk) disable iff (reset) full |-> !req_ready;
   endproperty
   a_full_block: assert property (p_full_block) else $error("ready while full");

   property p_read_seq;
      @(posedge clk) disable iff (reset)
         accept && (req_type == RT_MEM_RD || req_type == RT_MEM_RMW_RD || req_type == RT_IC_RD)
         |=> ctl_out == CC_REQ_NTL ##1 ctl_out == CC_REQ ##1 ctl_out == CC_IDLE;
   endproperty
   a_read_seq: assert property (p_read_seq) else $error("read code sequence wrong");

   property p_icw_seq;
      @(posedge clk) disable iff (reset) accept && req_type == RT_IC_WR
         |=> ctl_out == CC_REQ ##1 ctl_out == CC_REQ_NTL ##1 ctl_out == CC_REQ
         ##1 ctl_out == CC_IDLE;
   endproperty
   a_icw_seq: assert property (p_icw_seq) else $error("register write sequence wrong");

   property p_head;
      @(posedge clk) disable iff (reset) accept
         |=> md_out[15:12] == $past(req_type) && md_out[7:0] == $past(addr_fix[23:16])
         ##1 md_out == $past(addr_fix[15:0], 2) && md_oe;
   endproperty
   a_head: assert property (p_head) else $error("header or address order wrong");

   property p_ntl;
      @(posedge clk) disable iff (reset)
         busy && last_r >= 4'h2 && t_r == last_r - 4'h2 |=> ctl_out == CC_REQ_NTL;
   endproperty
   a_ntl: assert property (p_ntl) else $error("next-to-last code not 000");

   property p_len;
      @(posedge clk) disable iff (reset) accept && req_type == RT_MEM_WR
         |-> req_last == 4'h2 + {1'b0, req_len[3:1]};
   endproperty
   a_len: assert property (p_len) else $error("write length decode wrong");

   property p_even;
      @(posedge clk) disable iff (reset) accept && is_ic && req_two_byte
         |=> ##1 md_out[0] == 1'b0;
   endproperty
   a_even: assert property (p_even) else $error("odd two-byte register address");

   // ***************************************
   // header fields, data path and pipeline checks
   // ***************************************

   property p_ic_count;
      @(posedge clk) disable iff (reset)
         accept && is_ic |=> md_out[11:8] == {3'h0, $past(req_two_byte)};
   endproperty
   a_ic_count: assert property (p_ic_count) else $error("byte flag wrong");

   property p_mem_len;
      @(posedge clk) disable iff (reset)
         accept && !is_ic |=> md_out[11:8] == $past(req_len);
   endproperty
   a_mem_len: assert property (p_mem_len) else $error("length field wrong");

   property p_release;
      @(posedge clk) disable iff (reset)
         busy && t_r == last_r |=> ctl_out == CC_IDLE && !md_oe;
   endproperty
   a_release: assert property (p_release) else $error("lines not released");

   property p_data;
      @(posedge clk) disable iff (reset)
         wr_data_take |=> md_out == $past(wr_data) && md_oe;
   endproperty
   a_data: assert property (p_data) else $error("data pair not driven");

   property p_pipe_add;
      @(posedge clk) disable iff (reset)
         accept |=> ##1 pipe_count == $past(pipe_count, 2) + 2'h1;
   endproperty
   a_pipe_add: assert property (p_pipe_add) else $error("own request not counted");

   property p_no_overlap;
      @(posedge clk) disable iff (reset)
         (busy || msg_busy) |-> !req_ready;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("ready during message");

   c_read:  cover property (@(posedge clk) disable iff (reset) accept && req_type == RT_MEM_RD);
   c_write: cover property (@(posedge clk) disable iff (reset)
                            accept && req_type == RT_MEM_WR && req_len == 4'hF);
   c_retire: cover property (@(posedge clk) disable iff (reset) own_retire);
   c_icw:    cover property (@(posedge clk) disable iff (reset)
                            accept && req_type == RT_IC_WR);
endmodule

// ---- dv/mbrm_far_unit.sv ----
// far-side bus unit model: one-cycle replies and notices on command
`timescale 1ns/1ps
module mbrm_far_unit (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        go,
   input  wire logic [2:0]  code,
   input  wire logic [15:0] word,
   input  wire logic [15:0] md_bus,
   output logic [2:0]       ctl_o,
   output logic [15:0]      md_o,
   output logic             oe
);
   logic [15:0] word_r;
   logic [15:0] last_r;

   // one message cycle per go, then the lines go back to idle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         oe     <= 1'b0;
         ctl_o  <= 3'h7;
         word_r <= 16'h0000;
         last_r <= 16'h0000;
      end else begin
         oe     <= go;
         ctl_o  <= go ? code : 3'h7;
         word_r <= word;
         last_r <= md_bus;
      end
   end

   // released lines toggle so a stale value is never mistaken for data
   assign md_o = oe ? word_r : ~last_r;
endmodule

// ---- dv/mbrm_requester_tb.sv ----
// self-checking bench for the memory bus requester
`timescale 1ns/1ps
module mbrm_requester_tb;
   import mbrm_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_ready;
   mbrm_nib_t   req_type = 4'h0;
   mbrm_nib_t   req_len = 4'h0;
   logic        req_two_byte = 1'b0;
   logic [23:0] req_addr = 24'h000000;
   logic [15:0] wr_data;
   logic        wr_data_take;
   logic        bus_grant = 1'b1;
   mbrm_ccc_t   ctl_in;
   mbrm_ccc_t   ctl_out;
   logic        ctl_oe;
   logic [15:0] md_in;
   logic [15:0] md_out;
   logic        md_oe;
   logic [1:0]  pipe_count;
   logic        own_retire;
   logic        busy;
   logic        p_go = 1'b0;
   logic [2:0]  p_code = 3'h7;
   logic [2:0]  p_ctl;
   logic [15:0] p_md;
   logic        p_oe;
   int          wr_idx = 0;
   int          cyc = 0;
   int          error_cnt = 0;
   int          total_checks = 0;

   always #25 clk = ~clk;
   // shared lines: control pulled up to idle when nobody drives
   assign ctl_in  = ctl_oe ? ctl_out : (p_oe ? p_ctl : 3'h7);
   assign md_in   = md_oe ? md_out : p_md;
   assign wr_data = 16'hA000 + wr_idx[15:0];

   mbrm_requester dut (.clk(clk), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_type(req_type), .req_len(req_len),
      .req_two_byte(req_two_byte), .req_addr(req_addr), .wr_data(wr_data),
      .wr_data_take(wr_data_take), .bus_grant(bus_grant), .ctl_in(ctl_in),
      .ctl_out(ctl_out), .ctl_oe(ctl_oe), .md_in(md_in), .md_out(md_out),
      .md_oe(md_oe), .pipe_count(pipe_count), .own_retire(own_retire), .busy(busy));
   mbrm_far_unit far (.clk(clk), .reset(reset), .go(p_go), .code(p_code),
      .word(16'hFF12), .md_bus(md_in), .ctl_o(p_ctl), .md_o(p_md), .oe(p_oe));

   // data pairs restart at each accepted request and advance per consumed pair
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (req_valid === 1'b1 && req_ready === 1'b1) begin
         wr_idx <= 0;
      end else if (wr_data_take === 1'b1) begin
         wr_idx <= wr_idx + 1;
      end
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // sends one request and checks every message cycle on the bus
   task automatic issue(input mbrm_nib_t t, input mbrm_nib_t l, input logic two,
                        input logic [23:0] a, input logic [1:0] cnt);
      int n;
      int w;
      logic rd;
      logic [2:0] c;
      logic [15:0] m;
      logic [15:0] k;
      rd = (t == RT_MEM_RD || t == RT_MEM_RMW_RD || t == RT_IC_RD);
      n = (t == RT_IC_WR) ? 3 : rd ? 2 : 3 + l / 2;
      w = 0;
      @(posedge clk);
      req_type <= t;
      req_len <= l;
      req_two_byte <= two;
      req_addr <= a;
      req_valid <= 1'b1;
      do begin @(negedge clk); w++; end while (req_ready !== 1'b1 && w < 20);
      @(posedge clk);
      req_valid <= 1'b0;
      w = 0;
      do begin @(negedge clk); w++; end while (ctl_oe !== 1'b1 && w < 4);
      for (int i = 0; i < n; i++) begin
         c = (rd ? i == 0 : i == n - 2) ? 3'h0 : 3'h1;
         m = (i == 0) ? {t, t[2] ? {3'h0, two} : l, a[23:16]} :
             (i == 1) ? {a[15:1], a[0] & ~(t[2] & two)} : 16'hA000 + 16'(i - 2);
         k = (i >= 2 && i == n - 1 && !t[2] && !l[0]) ? 16'h00FF : 16'hFFFF;
         chk({3'h0, ctl_oe, md_oe, ctl_out, md_out & k},
             {5'h3, c, m & k}, "msg cycle");
         if (i < n - 1) @(negedge clk);
      end
      @(negedge clk);
      chk({ctl_oe, md_oe, ctl_out, pipe_count},
          {2'b00, 3'h7, cnt}, "after msg");
      chk(24'(wr_idx), rd ? 24'h0 : 24'(n - 2),
          "pairs taken");
   endtask

   task automatic far_send(input logic [2:0] code, input logic [1:0] cnt, input logic ret);
      logic r;
      @(posedge clk);
      p_go <= 1'b1;
      p_code <= code;
      @(posedge clk);
      p_go <= 1'b0;
      @(negedge clk);
      r = own_retire;
      @(negedge clk);
      chk({r, pipe_count}, {ret, cnt}, "pipeline after far message");
   endtask

   task automatic refused(input logic g);
      @(posedge clk);
      bus_grant <= g;
      req_valid <= 1'b1;
      @(negedge clk);
      chk(req_ready, 1'b0, "request accepted");
      @(posedge clk);
      req_valid <= 1'b0;
      bus_grant <= 1'b1;
   endtask

   task automatic t_reset();
      @(negedge clk);
      chk({busy, ctl_oe, md_oe, ctl_out, pipe_count, md_out},
          {3'h0, 3'h7, 2'h0, 16'h0}, "reset");
   endtask

   task automatic t_reads();
      issue(RT_MEM_RD, 4'hF, 1'b0, 24'hABCDEF, 2'd1);
      issue(RT_MEM_RMW_RD, 4'h0, 1'b0, 24'h123456, 2'd2);
      issue(RT_IC_RD, 4'h9, 1'b0, 24'h000101, 2'd3);
      refused(1'b1);
      far_send(3'h4, 2'd3, 1'b0);
      far_send(3'h2, 2'd2, 1'b1);
      far_send(3'h6, 2'd1, 1'b1);
      far_send(3'h2, 2'd0, 1'b1);
   endtask

   task automatic t_writes();
      refused(1'b0);
      issue(RT_MEM_WR, 4'h3, 1'b0, 24'h0A0B0C, 2'd1);
      issue(RT_MEM_RMW_WR, 4'h0, 1'b0, 24'h00FF01, 2'd2);
      issue(RT_IC_WR, 4'h0, 1'b1, 24'h000103, 2'd3);
      for (int i = 2; i >= 0; i--) far_send(3'h6, 2'(i), 1'b1);
      issue(RT_MEM_WR, 4'hF, 1'b0, 24'hFFFFFE, 2'd1);
      // foreign request queued behind own one, replies retire in arrival order
      far_send(3'h0, 2'd2, 1'b0);
      far_send(3'h6, 2'd1, 1'b1);
      far_send(3'h2, 2'd0, 1'b0);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_reads();
      t_writes();
      summarize();
   end
endmodule
